// *** core/tx_oh_pkg.sv ***
// package: register map, field positions and constants of the
// transmit overhead and line encoder block
// assumes: 8-bit registers, one apb word each, byte addr = 4 * index
package tx_oh_pkg;
  // register indices
  localparam logic [7:0] IDX_LINE_CODE = 8'h22;
  localparam logic [7:0] IDX_MAINT_ONE = 8'h2c;
  localparam logic [7:0] IDX_MAINT_TWO = 8'h31;
  localparam logic [7:0] IDX_FGEN = 8'h6c;
  localparam logic [7:0] IDX_TIMING = 8'h70;
  localparam logic [7:0] IDX_LB_CTRL = 8'h74;
  localparam logic [7:0] IDX_LB_PAT = 8'h75;
  localparam logic [7:0] IDX_RPT_CTRL = 8'h7f;
  localparam logic [7:0] IDX_MSG_CODE = 8'h80;
  localparam logic [7:0] IDX_MODE = 8'h90;
  localparam logic [7:0] IDX_STATUS = 8'h91;
  // every control register clears to this
  localparam logic [7:0] REG_RST = 8'h00;
  // field positions
  localparam int LC_SEL_BIT = 0;
  localparam int AUTO_ONES_BIT = 0;
  localparam int VIOL_BIT = 0;
  localparam int ONES_BIT = 0;
  localparam int ZEROS_BIT = 1;
  localparam int ALIGN_BIT = 2;
  localparam int TS_BIT = 0;
  localparam int LB_EN_BIT = 2;
  localparam int LB_UNF_BIT = 3;
  localparam int RPT_EN_BIT = 0;
  localparam int CR_BIT = 1;
  localparam int RV_BIT = 2;
  localparam int U1_BIT = 3;
  localparam int U2_BIT = 4;
  localparam int LBV_BIT = 5;
  localparam int MD_E1_BIT = 0;
  localparam int MD_ESF_BIT = 1;
  localparam int MD_MASTER_BIT = 2;
  localparam int MD_E1RATE_BIT = 3;
  // positions inside the 24-bit report word, sent lsb first
  localparam int RPT_CR_POS = 1;
  localparam int RPT_G6_POS = 8;
  localparam int RPT_G5_POS = 10;
  localparam int RPT_LV_POS = 14;
  localparam int RPT_G1_POS = 20;
  // crc-6 grade limits
  localparam logic [8:0] GR_ONE = 9'h001;
  localparam logic [8:0] GR_TWO_MAX = 9'h005;
  localparam logic [8:0] GR_THREE_MAX = 9'h00a;
  localparam logic [8:0] GR_FOUR_MAX = 9'h064;
  localparam logic [8:0] GR_FIVE_MAX = 9'h13f;
  localparam logic [8:0] GR_SIX_ABOVE = 9'h140;
  localparam logic [8:0] CRC_SAT = 9'h1ff;
  // message and report framing
  localparam logic [5:0] MSG_IDLE = 6'h3f;
  localparam logic [7:0] MSG_HEAD = 8'hfe;
  localparam logic [3:0] MSG_LAST = 4'he;
  localparam logic [4:0] RPT_LAST = 5'h17;
  localparam logic [7:0] SAPI_BASE = 8'h38;
  localparam logic [2:0] LB_LEN_M1_MIN = 3'h4;
  // line symbols and substitution patterns, oldest symbol first
  localparam logic [1:0] SYM_ZERO = 2'h0;
  localparam logic [1:0] SYM_MARK = 2'h1;
  localparam logic [1:0] SYM_VIOL = 2'h2;
  localparam logic [15:0] B8ZS_PAT = 16'h0249;
  localparam logic [7:0] HDB3_ODD = 8'h02;
  localparam logic [7:0] HDB3_EVEN = 8'h42;
  typedef enum logic [1:0] {
    CLK_RECOVERED = 2'b00,
    CLK_BACKPLANE = 2'b01,
    CLK_MASTER = 2'b10
  } clk_src_t;
endpackage : tx_oh_pkg

// *** core/line_enc_if.sv ***
// interface: processed bit stream from the overhead logic to the encoder
// assumes: both ends on clk_sys_i
`timescale 1ns/10ps
`default_nettype none
interface line_enc_if;
  logic stb;
  logic bit_v;
  logic sub_en;
  logic e1;
  logic viol_req;
  logic pos;
  logic neg;
  modport src (output stb, bit_v, sub_en, e1, viol_req, input pos, neg);
  modport enc (input stb, bit_v, sub_en, e1, viol_req, output pos, neg);
endinterface : line_enc_if
`default_nettype wire

// *** core/line_encoder.sv ***
// line encoder: ami with b8zs (t1) or hdb3 (e1) and violation insert
// assumes: one strobe per line bit; fixed 8-bit delay in every code
`timescale 1ns/10ps
`default_nettype none
module line_encoder
  import tx_oh_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  line_enc_if.enc lnk
);
  typedef struct packed {
    logic [7:0][1:0] sr;
    logic par;
    logic last_pos;
    logic viol_pend;
    logic pos;
    logic neg;
  } enc_t;
  enc_t st;
  enc_t nxt;
  logic [7:0][1:0] sh;
  logic pol;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  ////////////////////////////////////////////////////////////////////
  // symbols are marked on entry so the zero run is seen before it leaves
  always_comb
  begin
    nxt = st;
    sh = {st.sr[6:0], (lnk.bit_v ? SYM_MARK : SYM_ZERO)};
    pol = st.last_pos;
    if (st.sr[7] == SYM_MARK && !st.viol_pend)
      pol = !st.last_pos;
    if (lnk.viol_req)
      nxt.viol_pend = 1'b1;
    if (lnk.stb)
    begin
      if (st.sr[7] == SYM_ZERO)
      begin
        nxt.pos = 1'b0;
        nxt.neg = 1'b0;
      end
      else
      begin
        nxt.pos = pol;
        nxt.neg = !pol;
        nxt.last_pos = pol;
      end
      // a request in the consuming cycle stays pending
      if (st.sr[7] == SYM_MARK && st.viol_pend)
        nxt.viol_pend = lnk.viol_req;
      nxt.par = st.par ^ lnk.bit_v;
      if (lnk.sub_en && !lnk.e1 && sh == '0)
        sh = B8ZS_PAT;
      else if (lnk.sub_en && lnk.e1 && sh[3:0] == '0)
      begin
        sh[3:0] = st.par ? HDB3_ODD : HDB3_EVEN;
        nxt.par = 1'b0;
      end
      nxt.sr = sh;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st <= '0;
    else
      st <= nxt;
  end

  assign lnk.pos = st.pos;
  assign lnk.neg = st.neg;

  ////////////////////////////////////////////////////////////////////
  zero_space_a: assert property (lnk.stb && st.sr[7] == SYM_ZERO |=> !st.pos && !st.neg)
    else $error("zero symbol sent as a pulse");
  b8zs_fill_a: assert property (lnk.stb && lnk.sub_en && !lnk.e1 && !lnk.bit_v
    && st.sr[6:0] == '0 |=> st.sr == B8ZS_PAT)
    else $error("eight zeros not substituted");
  viol_same_a: assert property (lnk.stb && st.viol_pend && st.sr[7] == SYM_MARK
    |=> st.pos == $past(st.last_pos) && st.neg != st.pos)
    else $error("inserted violation kept alternate polarity");
endmodule : line_encoder
`default_nettype wire

// *** core/tx_overhead_top.sv ***
// top: transmit overhead insertion, overrides, alignment shift, clock
// selection and line encoder behind an apb register slave
// assumes: stream inputs and event pulses come from logic on clk_sys_i
// Contract
// - one crc grade bit from per-second count; a count of exactly 320 sets no grade bit
// - event flags set if counted in second
// - bit message only in t1 esf mode
// - message is 11111110, six code bits, 0
// - all-ones code suppresses the message
// - loopback code only while enabled
// - framed: channels overwritten, framing bit kept
// - unframed: channels and framing bit overwritten
// - all ones then all zeros, zeros win
// - alignment toggle edge deletes or repeats bit
// - master: bypass buffer, clock by select bit
// - t1 at e1 rate: buffer, select ignored
// - slave with select set: buffer, slip unlocked
// - slave with select clear: bypass, backplane clock
// - multiplexed mode behaves as clock slave
// - b8zs or hdb3 versus ami by select
// - rising insert bit adds one violation
// - auto bit and loss of signal: ones
// - report each second on data link
// - report control bits fill report positions
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none
module tx_overhead_top
  import tx_oh_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [9:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic bit_stb_i,
  input wire logic tx_data_i,
  input wire logic fbit_i,
  input wire logic dl_slot_i,
  input wire logic second_tick_i,
  input wire logic crc_err_i,
  input wire logic sef_err_i,
  input wire logic fbit_err_i,
  input wire logic line_viol_i,
  input wire logic slip_i,
  input wire logic rx_los_i,
  input wire logic clk_locked_i,
  output logic line_pos_o,
  output logic line_neg_o,
  output logic tx_buf_use_o,
  output logic [1:0] tx_clk_src_o,
  output logic buf_slip_o
);
  typedef struct packed {
    logic [7:0] line_code;
    logic [7:0] maint_one;
    logic [7:0] maint_two;
    logic [7:0] fgen;
    logic [7:0] timing;
    logic [7:0] lb_ctrl;
    logic [7:0] lb_pat;
    logic [7:0] rpt_ctrl;
    logic [7:0] msg_code;
    logic [7:0] mode;
    logic pready;
    logic pslverr;
    logic [7:0] rdata;
    logic prev_bit;
    logic align_tap;
    logic [8:0] crc_cnt;
    logic ev_sef;
    logic ev_fe;
    logic ev_lv;
    logic ev_sl;
    logic [23:0] rpt;
    logic rpt_valid;
    logic [1:0] rpt_seq;
    logic [4:0] rpt_idx;
    logic [3:0] bom_idx;
    logic [2:0] lb_idx;
    logic out_bit;
    logic out_stb;
    logic viol_req;
    logic buf_use;
    clk_src_t clk_src;
    logic slip;
  } top_t;
  top_t st;
  top_t nxt;

  logic setup;
  logic wr_en;
  logic hit;
  logic [7:0] rv;
  logic align_chg;
  logic viol_rise;
  logic al_bit;
  logic lb_bit;
  logic lb_active;
  logic lb_cover;
  logic [2:0] len_m1;
  logic t1_esf;
  logic msg_on;
  logic ones_on;
  logic zeros_on;
  logic tx_bit;
  logic [5:0] gr;
  logic [14:0] msg_word;

  line_enc_if lnk ();

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  ////////////////////////////////////////////////////////////////////
  // one-hot grade {six..one}; count of exactly 320 falls in no grade
  function automatic logic [5:0] grade_of(input logic [8:0] n);
    logic [5:0] g;
    g = 6'h00;
    if (n == GR_ONE)
      g = 6'h01;
    else if (n > GR_ONE && n <= GR_TWO_MAX)
      g = 6'h02;
    else if (n > GR_TWO_MAX && n <= GR_THREE_MAX)
      g = 6'h04;
    else if (n > GR_THREE_MAX && n <= GR_FOUR_MAX)
      g = 6'h08;
    else if (n > GR_FOUR_MAX && n <= GR_FIVE_MAX)
      g = 6'h10;
    else if (n > GR_SIX_ABOVE)
      g = 6'h20;
    return g;
  endfunction : grade_of

  // register index of a byte address
  function automatic logic [7:0] reg_idx(input logic [9:0] a);
    return a[9:2];
  endfunction : reg_idx

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt = st;
    // apb: decode in setup, answer with pready in first access cycle
    setup = psel_i && !penable_i;
    wr_en = psel_i && penable_i && st.pready && pwrite_i && !st.pslverr;
    hit = 1'b1;
    rv = REG_RST;
    case (reg_idx(paddr_i))
      IDX_LINE_CODE: rv = st.line_code;
      IDX_MAINT_ONE: rv = st.maint_one;
      IDX_MAINT_TWO: rv = st.maint_two;
      IDX_FGEN: rv = st.fgen;
      IDX_TIMING: rv = st.timing;
      IDX_LB_CTRL: rv = st.lb_ctrl;
      IDX_LB_PAT: rv = st.lb_pat;
      IDX_RPT_CTRL: rv = st.rpt_ctrl;
      IDX_MSG_CODE: rv = st.msg_code;
      IDX_MODE: rv = st.mode;
      IDX_STATUS: rv = {st.buf_use, st.slip, st.clk_src, st.rpt_seq,
                        st.align_tap, st.rpt_valid};
      default: hit = 1'b0;
    endcase
    nxt.pready = setup;
    if (setup)
    begin
      nxt.rdata = hit ? rv : REG_RST;
      nxt.pslverr = !hit || (paddr_i[1:0] != 2'b00);
    end
    // edge effects are taken from the write itself, not a later poll
    align_chg = wr_en && reg_idx(paddr_i) == IDX_FGEN
                && (pwdata_i[ALIGN_BIT] != st.fgen[ALIGN_BIT]);
    viol_rise = wr_en && reg_idx(paddr_i) == IDX_MAINT_TWO
                && pwdata_i[VIOL_BIT] && !st.maint_two[VIOL_BIT];
    nxt.align_tap = st.align_tap ^ align_chg;
    nxt.viol_req = viol_rise;
    if (wr_en)
    begin
      case (reg_idx(paddr_i))
        IDX_LINE_CODE: nxt.line_code = pwdata_i[7:0];
        IDX_MAINT_ONE: nxt.maint_one = pwdata_i[7:0];
        IDX_MAINT_TWO: nxt.maint_two = pwdata_i[7:0];
        IDX_FGEN: nxt.fgen = pwdata_i[7:0];
        IDX_TIMING: nxt.timing = pwdata_i[7:0];
        IDX_LB_CTRL: nxt.lb_ctrl = pwdata_i[7:0];
        IDX_LB_PAT: nxt.lb_pat = pwdata_i[7:0];
        IDX_RPT_CTRL: nxt.rpt_ctrl = pwdata_i[7:0];
        IDX_MSG_CODE: nxt.msg_code = pwdata_i[7:0];
        IDX_MODE: nxt.mode = pwdata_i[7:0];
        default: ;
      endcase
    end

    // per-second counts; an event in the tick cycle opens the new second
    gr = grade_of(st.crc_cnt);
    if (second_tick_i)
    begin
      if (st.rpt_ctrl[RPT_EN_BIT])
      begin
        nxt.rpt = {st.ev_fe, st.ev_sef, st.rpt_ctrl[LBV_BIT], gr[0],
                   st.rpt_ctrl[RV_BIT], gr[1], st.rpt_seq,
                   gr[2], st.ev_lv, gr[3], st.rpt_ctrl[U1_BIT],
                   st.rpt_ctrl[U2_BIT], gr[4], st.ev_sl, gr[5],
                   SAPI_BASE[7:2], st.rpt_ctrl[CR_BIT], 1'b0};
        nxt.rpt_valid = 1'b1;
        nxt.rpt_seq = st.rpt_seq + 2'b01;
      end
      nxt.crc_cnt = {8'h00, crc_err_i};
      nxt.ev_sef = sef_err_i;
      nxt.ev_fe = fbit_err_i;
      nxt.ev_lv = line_viol_i;
      nxt.ev_sl = slip_i;
    end
    else
    begin
      if (crc_err_i && st.crc_cnt != CRC_SAT)
        nxt.crc_cnt = st.crc_cnt + 9'h001;
      nxt.ev_sef = st.ev_sef | sef_err_i;
      nxt.ev_fe = st.ev_fe | fbit_err_i;
      nxt.ev_lv = st.ev_lv | line_viol_i;
      nxt.ev_sl = st.ev_sl | slip_i;
    end
    if (!st.rpt_ctrl[RPT_EN_BIT])
      nxt.rpt_valid = 1'b0;

    // stream: alignment tap, data link, loopback code, overrides
    al_bit = st.align_tap ? st.prev_bit : tx_data_i;
    t1_esf = !st.mode[MD_E1_BIT] && st.mode[MD_ESF_BIT];
    msg_on = t1_esf && st.msg_code[5:0] != MSG_IDLE;
    msg_word = {MSG_HEAD, st.msg_code[5:0], 1'b0};
    len_m1 = LB_LEN_M1_MIN + {1'b0, st.lb_ctrl[1:0]};
    lb_bit = st.lb_pat[len_m1 - st.lb_idx];
    lb_active = st.lb_ctrl[LB_EN_BIT] && !st.mode[MD_E1_BIT];
    lb_cover = lb_active && (!fbit_i || st.lb_ctrl[LB_UNF_BIT]);
    ones_on = st.fgen[ONES_BIT] || (st.maint_one[AUTO_ONES_BIT] && rx_los_i);
    zeros_on = st.fgen[ZEROS_BIT];
    tx_bit = al_bit;
    if (fbit_i && dl_slot_i && msg_on)
      tx_bit = msg_word[MSG_LAST - st.bom_idx];
    else if (fbit_i && dl_slot_i && t1_esf && st.rpt_valid)
      tx_bit = st.rpt[st.rpt_idx];
    if (lb_cover)
      tx_bit = lb_bit;
    if (ones_on)
      tx_bit = 1'b1;
    if (zeros_on)
      tx_bit = 1'b0;
    if (!msg_on)
      nxt.bom_idx = 4'h0;
    if (!lb_active)
      nxt.lb_idx = 3'h0;
    if (bit_stb_i)
    begin
      nxt.prev_bit = tx_data_i;
      nxt.out_bit = tx_bit;
      if (fbit_i && dl_slot_i && msg_on)
        nxt.bom_idx = (st.bom_idx == MSG_LAST) ? 4'h0 : st.bom_idx + 4'h1;
      else if (fbit_i && dl_slot_i && t1_esf && st.rpt_valid)
        nxt.rpt_idx = (st.rpt_idx == RPT_LAST) ? 5'h00 : st.rpt_idx + 5'h01;
      if (lb_cover)
        nxt.lb_idx = (st.lb_idx == len_m1) ? 3'h0 : st.lb_idx + 3'h1;
    end
    nxt.out_stb = bit_stb_i;

    // clock and buffer choice; multiplexed mode takes the slave path
    if (st.mode[MD_MASTER_BIT])
    begin
      nxt.buf_use = 1'b0;
      nxt.clk_src = st.timing[TS_BIT] ? CLK_MASTER : CLK_RECOVERED;
    end
    else if (st.mode[MD_E1RATE_BIT] && !st.mode[MD_E1_BIT])
    begin
      nxt.buf_use = 1'b1;
      nxt.clk_src = CLK_MASTER;
    end
    else
    begin
      nxt.buf_use = st.timing[TS_BIT];
      nxt.clk_src = st.timing[TS_BIT] ? CLK_MASTER : CLK_BACKPLANE;
    end
    nxt.slip = nxt.buf_use && !clk_locked_i;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st <= '0;
    else
      st <= nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // encoder sits behind the fixed-delay symbol line
  assign lnk.stb = st.out_stb;
  assign lnk.bit_v = st.out_bit;
  assign lnk.sub_en = st.line_code[LC_SEL_BIT];
  assign lnk.e1 = st.mode[MD_E1_BIT];
  assign lnk.viol_req = st.viol_req;

  line_encoder u_enc (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .lnk(lnk)
  );

  assign prdata_o = {24'h000000, st.rdata};
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;
  assign line_pos_o = lnk.pos;
  assign line_neg_o = lnk.neg;
  assign tx_buf_use_o = st.buf_use;
  assign tx_clk_src_o = st.clk_src;
  assign buf_slip_o = st.slip;

  ////////////////////////////////////////////////////////////////////
  sequence viol_pulse_s;
    st.viol_req ##1 !st.viol_req;
  endsequence

  apb_ready_a: assert property (setup |=> st.pready ##1 !st.pready)
    else $error("pready not one access cycle");
  grade_one_a: assert property (second_tick_i && st.rpt_ctrl[RPT_EN_BIT]
    && st.crc_cnt == GR_ONE |=> st.rpt[RPT_G1_POS] && !st.rpt[RPT_G6_POS])
    else $error("single crc error not graded one");
  grade_five_a: assert property (second_tick_i && st.rpt_ctrl[RPT_EN_BIT]
    && st.crc_cnt == GR_FIVE_MAX |=> st.rpt[RPT_G5_POS] && !st.rpt[RPT_G1_POS])
    else $error("grade five limit wrong");
  flag_lv_a: assert property (second_tick_i && st.rpt_ctrl[RPT_EN_BIT] && st.ev_lv
    |=> st.rpt[RPT_LV_POS] && st.rpt_valid)
    else $error("violation flag missing in report");
  cr_fill_a: assert property (second_tick_i && st.rpt_ctrl[RPT_EN_BIT]
    |=> st.rpt[RPT_CR_POS] == $past(st.rpt_ctrl[CR_BIT]))
    else $error("report cr bit not from control");
  msg_e1_a: assert property (st.mode[MD_E1_BIT] |=> st.bom_idx == 4'h0)
    else $error("bit message advanced in e1 mode");
  zeros_win_a: assert property (bit_stb_i && zeros_on |=> st.out_stb && !st.out_bit)
    else $error("all zeros not applied");
  ones_los_a: assert property (bit_stb_i && !zeros_on
    && st.maint_one[AUTO_ONES_BIT] && rx_los_i |=> st.out_bit)
    else $error("all ones not applied on los");
  lb_cover_a: assert property (bit_stb_i && lb_cover && !ones_on && !zeros_on
    |=> st.out_bit == $past(lb_bit))
    else $error("loopback code not overwriting");
  lb_fbit_a: assert property (bit_stb_i && lb_active && !st.lb_ctrl[LB_UNF_BIT]
    && fbit_i && !dl_slot_i && !ones_on && !zeros_on
    |=> st.out_bit == $past(al_bit))
    else $error("framed loopback changed framing bit");
  lb_off_a: assert property (!lb_active && !fbit_i && bit_stb_i && !ones_on
    && !zeros_on |=> st.out_bit == $past(al_bit) && st.lb_idx == 3'h0)
    else $error("loopback code active while disabled");
  align_flip_a: assert property (align_chg |=> st.align_tap != $past(st.align_tap))
    else $error("alignment tap not flipped");
  viol_pulse_a: assert property (viol_rise |=> viol_pulse_s)
    else $error("violation request not one pulse");
  master_clk_a: assert property (st.mode[MD_MASTER_BIT] |=> !st.buf_use
    && st.clk_src == ($past(st.timing[TS_BIT]) ? CLK_MASTER : CLK_RECOVERED))
    else $error("master clock choice wrong");
  e1rate_buf_a: assert property (!st.mode[MD_MASTER_BIT] && st.mode[MD_E1RATE_BIT]
    && !st.mode[MD_E1_BIT] |=> st.buf_use && st.clk_src == CLK_MASTER)
    else $error("e1 rate slave not buffered");
  slave_sel_a: assert property (!st.mode[MD_MASTER_BIT]
    && !st.mode[MD_E1RATE_BIT] |=> st.buf_use == $past(st.timing[TS_BIT])
    && (st.slip == (st.buf_use && !$past(clk_locked_i))))
    else $error("slave buffer choice wrong");
endmodule : tx_overhead_top
`default_nettype wire

// *** dv/line_side_model.sv ***
// partner: line interface and backplane timing; strobes the stream,
// pulses events and counts the symbols seen on the line outputs
// assumes: same clock as the block, one symbol held between strobes
`timescale 1ns/10ps
`default_nettype none
module line_side_model
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic lock_i,
  input wire logic los_i,
  input wire logic clr_i,
  input wire logic pos_i,
  input wire logic neg_i,
  output logic bit_stb_o,
  output logic tx_data_o,
  output logic fbit_o,
  output logic dl_slot_o,
  output logic second_tick_o,
  output logic [4:0] ev_o,
  output logic clk_locked_o,
  output logic rx_los_o,
  output logic [15:0] marks_o,
  output logic [15:0] viol_o
);
  logic [11:0] cyc_ff;
  logic [7:0] bitn_ff;
  logic odd_ff;
  logic last_ff;
  //////////////////////////////////////////////////////////////////////
  // one bit every fourth cycle leaves the encoder room; 193-bit frames
  assign bit_stb_o = (cyc_ff[1:0] == 2'h3);
  assign fbit_o = (bitn_ff == 8'h00);
  assign dl_slot_o = fbit_o & odd_ff;
  assign tx_data_o = bitn_ff[0] ^ bitn_ff[3];
  // a short second and one event per frame, so graded counts of one occur
  assign second_tick_o = (cyc_ff[9:0] == 10'h3ff);
  assign ev_o = {5{bit_stb_o && (bitn_ff == 8'h00)}};
  assign clk_locked_o = lock_i;
  assign rx_los_o = los_i;
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cyc_ff <= 12'h000;
      bitn_ff <= 8'h00;
      odd_ff <= 1'b0;
    end
    else
    begin
      cyc_ff <= cyc_ff + 12'h001;
      if (bit_stb_o)
      begin
        bitn_ff <= (bitn_ff == 8'hc0) ? 8'h00 : bitn_ff + 8'h01;
        odd_ff <= (bitn_ff == 8'hc0) ? ~odd_ff : odd_ff;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // symbol count at each strobe; a mark of the last mark's polarity
  // counts as a violation, polarity kept across clears
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      marks_o <= 16'h0000;
      viol_o <= 16'h0000;
      last_ff <= 1'b0;
    end
    else if (clr_i)
    begin
      marks_o <= 16'h0000;
      viol_o <= 16'h0000;
    end
    else if (bit_stb_o && (pos_i || neg_i))
    begin
      marks_o <= marks_o + 16'h0001;
      viol_o <= viol_o + {15'h0000, pos_i == last_ff};
      last_ff <= pos_i;
    end
  end
endmodule : line_side_model
`default_nettype wire

// *** dv/t1e1_tx_overhead_and_encoder_test.sv ***
// testbench: register, clock selection and line override tests
// assumes: zero-wait apb slave, model strobes every fourth cycle
`timescale 1ns/10ps
`default_nettype none
module t1e1_tx_overhead_and_encoder_test
  import tx_oh_pkg::*;
;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, lock = 1'b1, los = 1'b0, clr = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata_o;
  logic pready_o, pslverr_o, stb, dat, fb, dl, tick, lk, lo, pos, neg;
  logic buf_use, slip;
  logic [1:0] src;
  logic [4:0] ev;
  logic [15:0] marks, viol;
  int mismatches = 0;
  int checks_done = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  tx_overhead_top u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .bit_stb_i(stb),
    .tx_data_i(dat), .fbit_i(fb), .dl_slot_i(dl), .second_tick_i(tick),
    .crc_err_i(ev[0]), .sef_err_i(ev[1]), .fbit_err_i(ev[2]), .line_viol_i(ev[3]),
    .slip_i(ev[4]), .rx_los_i(lo), .clk_locked_i(lk), .line_pos_o(pos),
    .line_neg_o(neg), .tx_buf_use_o(buf_use), .tx_clk_src_o(src), .buf_slip_o(slip));
  line_side_model u_line (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .lock_i(lock),
    .los_i(los), .clr_i(clr), .pos_i(pos), .neg_i(neg), .bit_stb_o(stb),
    .tx_data_o(dat), .fbit_o(fb), .dl_slot_o(dl), .second_tick_o(tick), .ev_o(ev),
    .clk_locked_o(lk), .rx_los_o(lo), .marks_o(marks), .viol_o(viol));
  //////////////////////////////////////////////////////////////////////
  // one compare for every result, four-state exact
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // apb cycle; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1)
      @(posedge clk_sys_i);
    rd = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, wd, d, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 8'h00, d, e);
    chk("read data", {24'h0, exp}, d);
    chk("read error", 32'h0, {31'h0, e});
  endtask : rdc
  // flush the 8-symbol delay, then count 24 symbols; poke raises insert
  task automatic meas(input logic [15:0] m, input logic [15:0] v, input logic poke);
    repeat (48) @(posedge clk_sys_i);
    clr <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    if (poke)
      wr(IDX_MAINT_TWO, 8'h01);
    repeat (poke ? 93 : 96) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("marks", {16'h0, m}, {16'h0, marks});
    chk("violations", {16'h0, v}, {16'h0, viol});
  endtask : meas
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  //////////////////////////////////////////////////////////////////////
  // main sequence; clock table is {mode, select, lock, buffer, source, slip}
  initial
  begin
    static logic [7:0] regs [9] = '{IDX_LINE_CODE, IDX_MAINT_ONE, IDX_MAINT_TWO, IDX_FGEN,
      IDX_TIMING, IDX_LB_CTRL, IDX_LB_PAT, IDX_RPT_CTRL, IDX_MSG_CODE};
    static logic [9:0] tab [7] = '{10'b0000_0_1_0_01_0, 10'b0000_1_0_1_10_1,
      10'b0000_1_1_1_10_0, 10'b1000_0_0_1_10_1, 10'b0001_1_1_1_10_0,
      10'b0100_0_1_0_00_0, 10'b0100_1_0_0_10_0};
    logic [31:0] d;
    logic e;
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    foreach (regs[i])
      rdc(regs[i], REG_RST);
    wr(IDX_LB_PAT, 8'ha5);
    rdc(IDX_LB_PAT, 8'ha5);
    apb(1'b0, 8'h01, 8'h00, d, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    wr(IDX_RPT_CTRL, 8'h03);
    $display("test registers done");
    foreach (tab[i])
    begin
      lock <= tab[i][4];
      wr(IDX_MODE, {4'h0, tab[i][9:6]});
      wr(IDX_TIMING, {7'h0, tab[i][5]});
      repeat (3) @(posedge clk_sys_i);
      chk("buffer use", {31'h0, tab[i][3]}, {31'h0, buf_use});
      chk("buffer slip", {31'h0, tab[i][0]}, {31'h0, slip});
      chk("clock source", {30'h0, tab[i][2:1]}, {30'h0, src});
    end
    $display("test clock selection done");
    wr(IDX_MODE, 8'h00);
    wr(IDX_FGEN, 8'h01);
    meas(16'd24, 16'd0, 1'b0);
    meas(16'd24, 16'd1, 1'b1);
    wr(IDX_MAINT_TWO, 8'h00);
    wr(IDX_FGEN, 8'h03);
    meas(16'd0, 16'd0, 1'b0);
    wr(IDX_LINE_CODE, 8'h01);
    meas(16'd12, 16'd6, 1'b0);
    wr(IDX_FGEN, 8'h00);
    wr(IDX_LB_CTRL, 8'h0f);
    meas(16'd12, 16'd0, 1'b0);
    wr(IDX_LB_CTRL, 8'h00);
    los <= 1'b1;
    wr(IDX_MAINT_ONE, 8'h01);
    meas(16'd24, 16'd0, 1'b0);
    $display("test line overrides done");
    results();
  end
  // the run needs about 1000 cycles; cut a hang well beyond that
  initial
  begin
    #400000;
    mismatches++;
    results();
  end
endmodule : t1e1_tx_overhead_and_encoder_test
`default_nettype wire
